// ---- core/fpc_sync.v ----
// Two-stage synchroniser, one bit per lane
`timescale 1ns/1ns
module fpc_sync #(
    parameter W = 1
) (
    input  wire         i_mclk,
    input  wire         i_rst_b,
    input  wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end
    assign o_q = sync_q;
endmodule

// ---- core/fpc_top.v ----
// Fail-safe, reset, interrupt, select, IO and debug pin logic
`timescale 1ns/1ns
`include "fpc_consts.vh"
// Summary of operation
// - Latch rail select at restart until reread
// - Decode band into four rail pairs
// - Latched selection visible on status output
// - Select to pre-regulator: aux unused
// - Aux regulator disabled when unused
// - Interrupt output pulses low per event
// - Interrupt settings taken only during init
// - Long and short interrupt pulse lengths
// - IO0/IO1 wake on rise, fall, change
// - Wake inputs deglitched about 70 us
// - IO0/1 and IO4/5 paired safety inputs
// - Core feedback mismatch on IO1 flags fault
// - IO2/3 pair uses bi-stable protocol only
// - IO2/3 checked only in normal watchdog state
// - IO4/5 may drive external MOSFET gate
// - Fail-safe output low on qualifying fault
// - Fail-safe low after restart until released
// - Longest reset delay after restart
// - Fault resets use 1 ms or 10 ms
// - Reset delay writes accepted only in init
// - Debug mode if pin in band at start
// - Debug: fail-safe reasserted after release only by restart
// - Debug: watchdog errors cause no action
// - Debug forces CAN transceiver to normal
// - Debug left only via POR outside band
module fpc_top #(
    parameter IRQ_LONG_CYC  = `FPC_IRQ_LONG_CYC,
    parameter IRQ_SHORT_CYC = `FPC_IRQ_SHORT_CYC,
    parameter WU_DGL_CYC    = `FPC_WU_DGL_CYC,
    parameter RST_SHORT_CYC = `FPC_RST_SHORT_CYC,
    parameter RST_LONG_CYC  = `FPC_RST_LONG_CYC,
    parameter RST_POR_CYC   = `FPC_RST_POR_CYC
) (
    // Clock and reset
    input  wire       i_mclk,
    input  wire       i_rst_b,
    // Restart events
    input  wire       i_por,
    input  wire       i_low_power_off_wake,
    // Select pin comparator outputs
    input  wire [1:0] i_sel_band,
    input  wire       i_sel_to_pre,
    // Debug pin in-band comparator
    input  wire       i_debug_in_band,
    // Multi-purpose inputs
    input  wire [5:0] i_io,
    input  wire       i_core_fb_mismatch,
    // Configuration from SPI
    input  wire       i_init_phase,
    input  wire       i_cfg_wr,
    input  wire       i_cfg_irq_en,
    input  wire       i_cfg_irq_short,
    input  wire       i_cfg_rst_long,
    input  wire [1:0] i_cfg_wu0_mode,
    input  wire [1:0] i_cfg_wu1_mode,
    input  wire       i_cfg_safe01_en,
    input  wire       i_cfg_safe45_en,
    input  wire       i_cfg_safe23_en,
    input  wire       i_cfg_fb_chk_en,
    input  wire       i_cfg_gate45_en,
    input  wire [1:0] i_gate45_drive,
    // Fail-safe machine status
    input  wire       i_wd_running,
    input  wire       i_wd_error,
    input  wire       i_fault,
    input  wire       i_fault_reset,
    input  wire       i_irq_event,
    input  wire       i_release_wr,
    input  wire       i_wd_good,
    // Outputs
    output reg        o_irq_pulse_n,
    output reg        o_failsafe_out_n,
    output reg        o_reset_out_n,
    output reg  [1:0] o_rail_sel,
    output reg        o_aux_unused,
    output reg        o_aux_enable,
    output reg  [5:0] o_io_level,
    output reg  [1:0] o_wake,
    output reg        o_safety_fault,
    output reg        o_debug_mode,
    output reg        o_can_force_normal,
    output reg  [1:0] o_gate45,
    output reg        o_gate45_oe_n
);
    localparam ST_RST  = 3'b001;
    localparam ST_RUN  = 3'b010;
    localparam ST_HOLD = 3'b100;
    localparam CW = 20;

    wire [5:0] io_s;
    wire       dbg_s;
    reg  [5:0] io_prev_q;
    reg        restart_q;
    reg        irq_short_q;
    reg        irq_en_q;
    reg        rst_long_q;
    reg  [CW-1:0] irq_cnt_q;
    reg  [CW-1:0] rst_cnt_q;
    reg  [2:0]  rst_st_q;
    reg  [CW-1:0] dgl_cnt_q [0:1];
    reg  [1:0]  wu_arm_q;
    reg  [1:0]  wu_lvl_q;
    reg         released_q;

    function wu_edge;
        input [1:0] mode;
        input       cur;
        input       prv;
        begin
            case (mode)
                `FPC_WU_RISE: wu_edge = cur & ~prv;
                `FPC_WU_FALL: wu_edge = ~cur & prv;
                `FPC_WU_ANY:  wu_edge = cur ^ prv;
                default:      wu_edge = 1'b0;
            endcase
        end
    endfunction

    // End-of-count test shared by every down-counter
    function cnt_done;
        input [CW-1:0] cnt;
        begin
            cnt_done = (cnt == {CW{1'b0}});
        end
    endfunction

    // Reload value: a count of n runs from n-1 down to zero
    function [CW-1:0] cnt_load;
        input [31:0] n;
        begin
            cnt_load = n[CW-1:0] - 1'b1;
        end
    endfunction

    // Pair fault: the two lines of a safety pair must differ
    function pair_bad;
        input en;
        input a;
        input b;
        begin
            pair_bad = en & (a == b);
        end
    endfunction

    fpc_sync #(.W(7)) u_sync (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_d     ({i_debug_in_band, i_io}),
        .o_q     ({dbg_s, io_s})
    );

    wire restart = i_por | i_low_power_off_wake;

    // Select latch and restart bookkeeping
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rail_sel   <= `FPC_SEL_BAND_33_33;
            o_aux_unused <= 1'b0;
            o_aux_enable <= 1'b0;
            restart_q    <= 1'b1;
            io_prev_q    <= 6'h00;
            o_io_level   <= 6'h00;
        end else begin
            restart_q  <= restart;
            io_prev_q  <= io_s;
            o_io_level <= io_s;
            if (restart) begin
                o_rail_sel   <= i_sel_band;
                o_aux_unused <= i_sel_to_pre;
                o_aux_enable <= ~i_sel_to_pre;
            end
        end
    end

    // Configuration latched only during init; later writes dropped
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_en_q    <= 1'b1;
            irq_short_q <= 1'b0;
            rst_long_q  <= 1'b0;
        end else if (restart) begin
            irq_en_q    <= 1'b1;
            irq_short_q <= 1'b0;
            rst_long_q  <= 1'b0;
        end else if (i_cfg_wr && i_init_phase) begin
            irq_en_q    <= i_cfg_irq_en;
            irq_short_q <= i_cfg_irq_short;
            rst_long_q  <= i_cfg_rst_long;
        end
    end

    // Interrupt pulse timer; a new event restarts the pulse
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_cnt_q     <= {CW{1'b0}};
            o_irq_pulse_n <= 1'b1;
        end else if (i_irq_event && irq_en_q) begin
            irq_cnt_q     <= irq_short_q ? cnt_load(IRQ_SHORT_CYC)
                                         : cnt_load(IRQ_LONG_CYC);
            o_irq_pulse_n <= 1'b0;
        end else if (!cnt_done(irq_cnt_q)) begin
            irq_cnt_q     <= irq_cnt_q - 1'b1;
        end else begin
            o_irq_pulse_n <= 1'b1;
        end
    end

    // Wake-up detect with deglitch on IO0 and IO1
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_wu
            wire [1:0] mode = (g == 0) ? i_cfg_wu0_mode : i_cfg_wu1_mode;
            always @(posedge i_mclk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    dgl_cnt_q[g] <= {CW{1'b0}};
                    wu_arm_q[g]  <= 1'b0;
                    wu_lvl_q[g]  <= 1'b0;
                    o_wake[g]    <= 1'b0;
                end else begin
                    o_wake[g] <= 1'b0;
                    if (wu_edge(mode, io_s[g], io_prev_q[g])) begin
                        wu_arm_q[g]  <= 1'b1;
                        wu_lvl_q[g]  <= io_s[g];
                        dgl_cnt_q[g] <= cnt_load(WU_DGL_CYC);
                    end else if (wu_arm_q[g]) begin
                        if (io_s[g] != wu_lvl_q[g]) begin
                            wu_arm_q[g] <= 1'b0; // Glitch dropped
                        end else if (cnt_done(dgl_cnt_q[g])) begin
                            wu_arm_q[g] <= 1'b0;
                            o_wake[g]   <= 1'b1;
                        end else begin
                            dgl_cnt_q[g] <= dgl_cnt_q[g] - 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    // Safety pairs: complementary levels expected on each pair
    wire pair01_bad = pair_bad(i_cfg_safe01_en, io_s[0], io_s[1]);
    wire pair45_bad = pair_bad(i_cfg_safe45_en & ~i_cfg_gate45_en, io_s[4], io_s[5]);
    wire fb_bad     = i_cfg_fb_chk_en && i_core_fb_mismatch;
    // Bi-stable only: normal phase is IO2 high, IO3 low
    wire pair23_bad = i_cfg_safe23_en && i_wd_running
                      && !(io_s[2] && !io_s[3]);
    wire safety_bad = pair01_bad | pair45_bad | fb_bad | pair23_bad;

    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_safety_fault <= 1'b0;
            o_gate45       <= 2'h0;
            o_gate45_oe_n  <= 1'b1;
        end else begin
            o_safety_fault <= safety_bad;
            o_gate45       <= i_cfg_gate45_en ? i_gate45_drive : 2'h0;
            o_gate45_oe_n  <= ~i_cfg_gate45_en;
        end
    end

    // Debug mode sampled once per power-on; wake keeps it
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_debug_mode       <= 1'b0;
            o_can_force_normal <= 1'b0;
        end else if (i_por) begin
            o_debug_mode       <= dbg_s;
            o_can_force_normal <= dbg_s;
        end
    end

    wire wd_err_eff = i_wd_error & ~o_debug_mode;
    wire fs_fault   = i_fault | safety_bad | wd_err_eff;

    // Fail-safe output
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_failsafe_out_n <= 1'b0;
            released_q       <= 1'b0;
        end else if (restart) begin
            o_failsafe_out_n <= 1'b0;
            released_q       <= 1'b0;
        end else if (released_q && o_debug_mode) begin
            o_failsafe_out_n <= 1'b1;
        end else if (fs_fault) begin
            o_failsafe_out_n <= 1'b0;
            released_q       <= 1'b0;
        end else if (i_release_wr && (i_wd_good || !o_debug_mode)) begin
            o_failsafe_out_n <= 1'b1;
            released_q       <= 1'b1;
        end
    end

    // Reset output sequencer
    // Requests while reset is low are dropped, not queued
    wire rst_req = i_fault_reset | wd_err_eff;
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_st_q      <= ST_RST;
            rst_cnt_q     <= RST_POR_CYC[CW-1:0] - 1'b1;
            o_reset_out_n <= 1'b0;
        end else if (restart) begin
            rst_st_q      <= ST_RST;
            rst_cnt_q     <= cnt_load(RST_POR_CYC);
            o_reset_out_n <= 1'b0;
        end else begin
            case (rst_st_q)
                ST_RST: begin
                    if (cnt_done(rst_cnt_q)) begin
                        rst_st_q      <= ST_RUN;
                        o_reset_out_n <= 1'b1;
                    end else begin
                        rst_cnt_q <= rst_cnt_q - 1'b1;
                    end
                end
                ST_RUN: begin
                    if (rst_req) begin
                        rst_st_q      <= ST_HOLD;
                        o_reset_out_n <= 1'b0;
                        rst_cnt_q     <= rst_long_q ? cnt_load(RST_LONG_CYC)
                                                    : cnt_load(RST_SHORT_CYC);
                    end
                end
                ST_HOLD: begin
                    if (cnt_done(rst_cnt_q)) begin
                        rst_st_q      <= ST_RUN;
                        o_reset_out_n <= 1'b1;
                    end else begin
                        rst_cnt_q <= rst_cnt_q - 1'b1;
                    end
                end
                default: begin
                    rst_st_q <= ST_RST;
                end
            endcase
        end
    end
endmodule

// ---- shared/fpc_consts.vh ----
// Constants for the fail-safe pin control block
`ifndef FPC_CONSTS_VH
`define FPC_CONSTS_VH
`define FPC_CLK_MHZ          25
`define FPC_T_IRQ_LONG_US    100
`define FPC_T_IRQ_SHORT_US   25
`define FPC_T_WU_DGL_US      70
`define FPC_T_RST_SHORT_US   1000
`define FPC_T_RST_LONG_US    10000
`define FPC_T_RST_POR_US     20000
`define FPC_IRQ_LONG_CYC     (`FPC_T_IRQ_LONG_US * `FPC_CLK_MHZ)
`define FPC_IRQ_SHORT_CYC    (`FPC_T_IRQ_SHORT_US * `FPC_CLK_MHZ)
`define FPC_WU_DGL_CYC       (`FPC_T_WU_DGL_US * `FPC_CLK_MHZ)
`define FPC_RST_SHORT_CYC    (`FPC_T_RST_SHORT_US * `FPC_CLK_MHZ)
`define FPC_RST_LONG_CYC     (`FPC_T_RST_LONG_US * `FPC_CLK_MHZ)
`define FPC_RST_POR_CYC      (`FPC_T_RST_POR_US * `FPC_CLK_MHZ)
`define FPC_SEL_BAND_33_33   2'h0
`define FPC_SEL_BAND_50_50   2'h1
`define FPC_SEL_BAND_33_50   2'h2
`define FPC_SEL_BAND_50_33   2'h3
`define FPC_WU_RISE          2'h0
`define FPC_WU_FALL          2'h1
`define FPC_WU_ANY           2'h2
`define FPC_WU_OFF           2'h3
`endif

// ---- tb/fpc_mcu_model.sv ----
// Microcontroller side: measures low widths of irq and reset lines
`timescale 1ns/1ns
module fpc_mcu_model (
    // Clock and reset
    input  wire         i_mclk,
    input  wire         i_rst_b,
    // Watched pins
    input  wire         i_irq_pulse_n,
    input  wire         i_reset_out_n,
    // Last low widths in cycles
    output logic [15:0] o_irq_w,
    output logic [15:0] o_rst_w
);
    logic [15:0] irq_cnt_q;
    logic [15:0] rst_cnt_q;
    // Counts from reset release, so restart delay includes no bench reset time
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_cnt_q <= 16'h0;
            rst_cnt_q <= 16'h0;
            o_irq_w   <= 16'h0;
            o_rst_w   <= 16'h0;
        end else begin
            irq_cnt_q <= i_irq_pulse_n ? 16'h0 : irq_cnt_q + 16'h1;
            rst_cnt_q <= i_reset_out_n ? 16'h0 : rst_cnt_q + 16'h1;
            if (i_irq_pulse_n && irq_cnt_q != 16'h0) o_irq_w <= irq_cnt_q;
            if (i_reset_out_n && rst_cnt_q != 16'h0) o_rst_w <= rst_cnt_q;
        end
    end
endmodule

// ---- tb/fpc_properties.sv ----
// Checker for the fail-safe pin control outputs
`timescale 1ns/1ns
module fpc_properties (
    // Clock, reset and causes
    input wire       i_mclk,
    input wire       i_rst_b,
    input wire       i_por,
    input wire       i_low_power_off_wake,
    input wire [1:0] i_sel_band,
    input wire       i_sel_to_pre,
    input wire       i_cfg_gate45_en,
    input wire [1:0] i_gate45_drive,
    input wire       i_wd_error,
    input wire       i_fault_reset,
    input wire       i_irq_event,
    // Watched outputs
    input wire       o_irq_pulse_n,
    input wire       o_failsafe_out_n,
    input wire       o_reset_out_n,
    input wire [1:0] o_rail_sel,
    input wire       o_aux_unused,
    input wire       o_aux_enable,
    input wire       o_debug_mode,
    input wire       o_can_force_normal,
    input wire [1:0] o_gate45,
    input wire       o_gate45_oe_n
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    // Shortest irq pulse width (4) with the reduced bench counts; reset low checked for 8 of its 10 cycles
    sequence s_irq_low; !o_irq_pulse_n [*4]; endsequence
    sequence s_rst_low; !o_reset_out_n [*8]; endsequence
    wire restart = i_por || i_low_power_off_wake;

    a_rail_sel_load: assert property (restart && !i_sel_to_pre |=>
        o_rail_sel == $past(i_sel_band)) else $error("rail select not latched");
    a_rail_sel_hold: assert property (!$past(i_por) && !$past(i_low_power_off_wake) |->
        $stable(o_rail_sel)) else $error("rail select moved");
    a_aux_off: assert property (restart && i_sel_to_pre |=>
        o_aux_unused && !o_aux_enable) else $error("aux rail not off");
    a_irq_cause: assert property ($fell(o_irq_pulse_n) |-> $past(i_irq_event))
        else $error("irq pulse without event");
    a_irq_width: assert property ($fell(o_irq_pulse_n) |-> s_irq_low)
        else $error("irq pulse too short");
    a_rst_on_fault: assert property (o_reset_out_n && i_fault_reset && !o_debug_mode
        |=> !o_reset_out_n) else $error("fault reset missed");
    a_rst_width: assert property ($fell(o_reset_out_n) |-> s_rst_low)
        else $error("reset pulse too short");
    a_wd_err_ignored: assert property (o_debug_mode && o_reset_out_n && i_wd_error
        && !i_fault_reset && !restart |=> o_reset_out_n) else $error("debug reset");
    a_fs_restart: assert property (restart |-> ##[1:2] !o_failsafe_out_n)
        else $error("fail-safe not held after restart");
    a_fs_debug_free: assert property (o_debug_mode && o_failsafe_out_n && !restart
        |=> o_failsafe_out_n) else $error("fail-safe reasserted in debug");
    a_gate_drive: assert property ($past(i_cfg_gate45_en) |-> !o_gate45_oe_n
        && o_gate45 == $past(i_gate45_drive)) else $error("gate drive wrong");
    a_can_debug: assert property ($past(o_debug_mode) && o_debug_mode
        |-> o_can_force_normal) else $error("can not forced in debug");
endmodule

// ---- tb/fpc_top_tb.sv ----
// Testbench for the fail-safe pin control block
`timescale 1ns/1ns
module fpc_top_tb;
    logic i_mclk = 0, i_rst_b = 0, i_por = 0, i_low_power_off_wake = 0, i_sel_to_pre = 0;
    logic i_debug_in_band = 0, i_core_fb_mismatch = 0, i_init_phase = 0, i_cfg_wr = 0;
    logic i_cfg_irq_en = 1, i_cfg_irq_short = 0, i_cfg_rst_long = 0, i_cfg_safe01_en = 0;
    logic i_cfg_safe45_en = 0, i_cfg_safe23_en = 0, i_cfg_fb_chk_en = 0, i_cfg_gate45_en = 0;
    logic i_wd_running = 0, i_wd_error = 0, i_fault = 0, i_fault_reset = 0, i_irq_event = 0;
    logic i_release_wr = 0, i_wd_good = 0;
    logic [1:0] i_sel_band = 0, i_cfg_wu0_mode = 3, i_cfg_wu1_mode = 3, i_gate45_drive = 0;
    logic [5:0] i_io = 6'h02;
    wire o_irq_pulse_n, o_failsafe_out_n, o_reset_out_n, o_aux_unused, o_aux_enable;
    wire o_safety_fault, o_debug_mode, o_can_force_normal, o_gate45_oe_n;
    wire [1:0] o_rail_sel, o_wake, o_gate45;
    wire [5:0] o_io_level;
    logic [15:0] irq_w, rst_w, w0, w1;
    integer err_count = 0, n_compared = 0;
    always #20 i_mclk = ~i_mclk;
    fpc_top #(.IRQ_LONG_CYC(8), .IRQ_SHORT_CYC(4), .WU_DGL_CYC(6), .RST_SHORT_CYC(10),
        .RST_LONG_CYC(16), .RST_POR_CYC(20)) fpc_top_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_por(i_por), .i_low_power_off_wake(i_low_power_off_wake), .i_sel_band(i_sel_band),
        .i_sel_to_pre(i_sel_to_pre), .i_debug_in_band(i_debug_in_band), .i_io(i_io),
        .i_core_fb_mismatch(i_core_fb_mismatch), .i_init_phase(i_init_phase),
        .i_cfg_wr(i_cfg_wr), .i_cfg_irq_en(i_cfg_irq_en), .i_cfg_irq_short(i_cfg_irq_short),
        .i_cfg_rst_long(i_cfg_rst_long), .i_cfg_wu0_mode(i_cfg_wu0_mode),
        .i_cfg_wu1_mode(i_cfg_wu1_mode), .i_cfg_safe01_en(i_cfg_safe01_en),
        .i_cfg_safe45_en(i_cfg_safe45_en), .i_cfg_safe23_en(i_cfg_safe23_en),
        .i_cfg_fb_chk_en(i_cfg_fb_chk_en), .i_cfg_gate45_en(i_cfg_gate45_en),
        .i_gate45_drive(i_gate45_drive), .i_wd_running(i_wd_running), .i_wd_error(i_wd_error),
        .i_fault(i_fault), .i_fault_reset(i_fault_reset), .i_irq_event(i_irq_event),
        .i_release_wr(i_release_wr), .i_wd_good(i_wd_good), .o_irq_pulse_n(o_irq_pulse_n),
        .o_failsafe_out_n(o_failsafe_out_n), .o_reset_out_n(o_reset_out_n),
        .o_rail_sel(o_rail_sel), .o_aux_unused(o_aux_unused), .o_aux_enable(o_aux_enable),
        .o_io_level(o_io_level), .o_wake(o_wake), .o_safety_fault(o_safety_fault),
        .o_debug_mode(o_debug_mode), .o_can_force_normal(o_can_force_normal),
        .o_gate45(o_gate45), .o_gate45_oe_n(o_gate45_oe_n));
    fpc_mcu_model fpc_mcu_model_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_irq_pulse_n(o_irq_pulse_n), .i_reset_out_n(o_reset_out_n),
        .o_irq_w(irq_w), .o_rst_w(rst_w));
    // One-cycle wake pulses are counted so no check can miss them
    always @(posedge i_mclk) if (!i_rst_b) {w0, w1} <= 0;
        else begin w0 <= w0 + o_wake[0]; w1 <= w1 + o_wake[1]; end
    task chk(input [15:0] got, input [15:0] lo, input [15:0] hi);
        n_compared = n_compared + 1;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_count = err_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask
    task cyc(input integer n); repeat (n) @(posedge i_mclk); endtask
    // Waits past the edge that drops reset, then one more so the model latches the width
    task wait_rst; integer k;
        @(negedge i_mclk);
        for (k = 0; k < 100 && o_reset_out_n !== 1'b1; k = k + 1) @(negedge i_mclk);
        @(negedge i_mclk);
    endtask
    task restart(input logic por);
        @(posedge i_mclk) if (por) i_por <= 1; else i_low_power_off_wake <= 1;
        @(posedge i_mclk) {i_por, i_low_power_off_wake} <= 2'b00;
        wait_rst;
    endtask
    task cfg(input logic init, input logic short_irq, input logic long_rst);
        @(posedge i_mclk) {i_init_phase, i_cfg_irq_short} <= {init, short_irq};
        i_cfg_rst_long <= long_rst;
        i_cfg_wr <= 1;
        @(posedge i_mclk) {i_cfg_wr, i_init_phase} <= 2'b00;
    endtask
    task fire(input logic rst, input [15:0] w);
        @(posedge i_mclk) if (rst) i_fault_reset <= 1; else i_irq_event <= 1;
        @(posedge i_mclk) {i_fault_reset, i_irq_event} <= 2'b00;
        cyc(12);
        wait_rst;
        @(negedge i_mclk) chk(rst ? rst_w : irq_w, w, w + 16'h2);
    endtask
    task pulse_rel(input logic good);
        @(posedge i_mclk) {i_release_wr, i_wd_good} <= {1'b1, good};
        @(posedge i_mclk) i_release_wr <= 0;
        @(negedge i_mclk);
    endtask
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        cyc(6);
        i_rst_b <= 1;
        wait_rst; chk(rst_w, 20, 22); chk(o_failsafe_out_n, 0, 0);
        for (int b = 0; b < 4; b++) begin
            @(posedge i_mclk) i_sel_band <= b[1:0];
            restart(1);
            @(posedge i_mclk) i_sel_band <= b[1:0] + 2'h1;
            cyc(2); @(negedge i_mclk) chk(o_rail_sel, b, b);
        end
        restart(0); chk(rst_w, 20, 22);
        @(posedge i_mclk) i_sel_to_pre <= 1;
        restart(1); chk({o_aux_unused, o_aux_enable}, 2, 2);
        $display("test restart done");
        fire(0, 8); cfg(1, 1, 1); fire(0, 4); fire(1, 16);
        cfg(0, 0, 0); fire(0, 4); fire(1, 16);
        restart(1); fire(1, 10); fire(0, 8);
        @(posedge i_mclk) i_cfg_irq_en <= 0;
        cfg(1, 0, 0);
        @(posedge i_mclk) i_irq_event <= 1;
        @(posedge i_mclk) i_irq_event <= 0;
        @(negedge i_mclk) chk(o_irq_pulse_n, 1, 1);
        $display("test config done");
        pulse_rel(0); chk(o_failsafe_out_n, 1, 1);
        @(posedge i_mclk) i_fault <= 1; @(posedge i_mclk) i_fault <= 0;
        @(negedge i_mclk) chk(o_failsafe_out_n, 0, 0);
        @(posedge i_mclk) {i_cfg_safe23_en, i_wd_running, i_io[3:2]} <= 4'b1101;
        cyc(5); @(negedge i_mclk) chk(o_safety_fault, 0, 0);
        @(posedge i_mclk) {i_wd_running, i_io[3:2]} <= 3'b000;
        cyc(5); @(negedge i_mclk) chk(o_safety_fault, 0, 0);
        @(posedge i_mclk) i_wd_running <= 1;
        cyc(5); @(negedge i_mclk) chk(o_safety_fault, 1, 1);
        @(posedge i_mclk) {i_cfg_safe23_en, i_cfg_safe01_en, i_io[1:0]} <= 4'b0111;
        cyc(5); @(negedge i_mclk) chk({o_safety_fault, o_failsafe_out_n}, 2, 2);
        @(posedge i_mclk) {i_cfg_safe01_en, i_io[1:0], i_cfg_wu0_mode, i_cfg_wu1_mode} <= 7'h01;
        @(posedge i_mclk) {i_cfg_safe45_en, i_io[5:4]} <= 3'b110;
        cyc(5); @(negedge i_mclk) chk(o_safety_fault, 0, 0);
        @(posedge i_mclk) i_io[4] <= 1;
        cyc(5); @(negedge i_mclk) chk(o_safety_fault, 1, 1);
        @(posedge i_mclk) {i_io[4], i_cfg_fb_chk_en, i_core_fb_mismatch} <= 3'b011;
        cyc(5); @(negedge i_mclk) chk(o_safety_fault, 1, 1);
        @(posedge i_mclk) i_core_fb_mismatch <= 0;
        cyc(5); @(negedge i_mclk) chk(o_safety_fault, 0, 0);
        $display("test safety done");
        @(posedge i_mclk) i_io[0] <= 1; cyc(3); @(posedge i_mclk) i_io[0] <= 0;
        cyc(14); @(negedge i_mclk) chk(w0, 0, 0);
        @(posedge i_mclk) {i_io[1], i_io[0]} <= 2'b01;
        cyc(14); @(negedge i_mclk) chk(w1, 1, 1); chk(w0, 1, 1);
        @(posedge i_mclk) {i_cfg_wu0_mode, i_io[0]} <= {2'h2, 1'b0};
        cyc(14); @(negedge i_mclk) chk(w0, 2, 2);
        @(posedge i_mclk) {i_cfg_gate45_en, i_gate45_drive} <= 3'b110;
        cyc(3); @(negedge i_mclk) chk({o_gate45_oe_n, o_gate45}, 2, 2);
        chk(o_io_level, 16'h20, 16'h20);
        $display("test wake and gate done");
        @(posedge i_mclk) i_debug_in_band <= 1; cyc(4); restart(1);
        chk({o_debug_mode, o_can_force_normal}, 3, 3);
        pulse_rel(0); chk(o_failsafe_out_n, 0, 0);
        pulse_rel(1); chk(o_failsafe_out_n, 1, 1);
        @(posedge i_mclk) {i_fault, i_wd_error} <= 2'b11;
        @(posedge i_mclk) {i_fault, i_wd_error} <= 2'b00;
        cyc(3); @(negedge i_mclk) chk({o_failsafe_out_n, o_reset_out_n}, 3, 3);
        @(posedge i_mclk) i_debug_in_band <= 0; cyc(4); restart(0);
        chk(o_debug_mode, 1, 1); restart(1); chk(o_debug_mode, 0, 0);
        $display("test debug done");
        final_report;
    end
    initial begin
        cyc(3000);
        err_count = err_count + 1;
        final_report;
    end
endmodule
bind fpc_top fpc_properties fpc_properties_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_por(i_por),
    .i_low_power_off_wake(i_low_power_off_wake), .i_sel_band(i_sel_band), .i_sel_to_pre(i_sel_to_pre),
    .i_cfg_gate45_en(i_cfg_gate45_en), .i_gate45_drive(i_gate45_drive),
    .i_wd_error(i_wd_error), .i_fault_reset(i_fault_reset), .i_irq_event(i_irq_event),
    .o_irq_pulse_n(o_irq_pulse_n), .o_failsafe_out_n(o_failsafe_out_n),
    .o_reset_out_n(o_reset_out_n), .o_rail_sel(o_rail_sel), .o_aux_unused(o_aux_unused),
    .o_aux_enable(o_aux_enable), .o_debug_mode(o_debug_mode),
    .o_can_force_normal(o_can_force_normal), .o_gate45(o_gate45), .o_gate45_oe_n(o_gate45_oe_n));
